/* sap_core.sv */
// Sound assignment procedure engine with its APB register slave.
// Assumes decoded track packets arrive as APB writes from the host CPU,
// and a sound library that reports the size of the addressed group.
`include "sap_defs.svh"

// Overview of operation
// - Selector 128-137, 141, 142 start background sound group selection.
// - Blow-off sample chosen under 133 is the one its key mapping plays.
// - Background selection works like chuff selection; regulator sets volume.
// - A key with output mapping and sound activates both when pressed.
// - Function allocation may browse across sample groups.
// - F0 plays the current sample for evaluation.
// - F1 and F2 step to previous or next sample and play it.
// - F4 and F5 change group and play its first sample, except in background selection, where they warn.
// - Regulator value sets the selected sound volume during a procedure.
// - F6 on at exit stores looping between markers while key held.
// - F7 on with F6 off at exit stores shortened playback while key held.
// - Neither F6 nor F7 stores full-length playback.
// - F3 ends the procedure and removes the sound of the target.
// - F8 ends the procedure and stores the last selected sample.
// - Other programming or power loss aborts and keeps old allocation.
// - Warning jingle at list ends, empty playback or invalid key.
// - Confirmation jingle after ending with F3 or F8.
// - Eight random generators, allocated by selector 101 onward.
// - Random allocation: F6 means standstill (default), F7 alone means moving.
// - Selector 111-113 allocate to switch inputs like function keys.
// - Selector writes are never stored; they only steer the keys.
// - Engine stays drivable; function outputs ignore keys while active.
module sap_core #(
  parameter int NUM_GROUPS = 16
) (
  input  logic                     ref_clk,
  input  logic                     rst,
  input  sap_pkg::sap_apb_req_t    apb_req,
  output sap_pkg::sap_apb_rsp_t    apb_rsp,
  input  logic [7:0]               lib_group_size,
  output sap_pkg::sap_play_t       play,
  output logic                     warn_jingle,
  output logic                     confirm_jingle,
  output sap_pkg::sap_store_t      store,
  output logic [`SAP_NUM_KEYS-1:0] func_out,
  output logic [`SAP_NUM_KEYS-1:0] key_sound,
  output logic                     blowoff_play,
  output logic [7:0]               blowoff_group,
  output logic [7:0]               blowoff_sample,
  output logic [7:0]               drive_speed,
  output logic                     drive_dir,
  output logic                     proc_active
);
  import sap_pkg::*;

  // Group index is 8 bits wide
  if (NUM_GROUPS < 1 || NUM_GROUPS > 256) begin : g_chk
    $error("NUM_GROUPS must lie in 1..256");
  end

  localparam logic [7:0] LAST_GROUP = 8'(NUM_GROUPS - 1);

  sap_regs_t r_ff;
  sap_regs_t nxt_r;

  logic                     acc;
  logic                     commit;
  logic [`SAP_NUM_KEYS-1:0] press;
  logic [7:0]               sel_val;

  // Bus phase decode and key edge detection
  assign acc     = apb_req.psel & apb_req.penable;
  assign commit  = acc & r_ff.apb.pready & apb_req.pwrite;
  assign press   = r_ff.keys & ~r_ff.keys_prev;
  assign sel_val = apb_req.pwdata[7:0];

  // Next-state logic for bus slave and procedure engine
  always_comb begin
    nxt_r = r_ff;
    nxt_r.play.strobe  = 1'b0;
    nxt_r.warn         = 1'b0;
    nxt_r.confirm      = 1'b0;
    nxt_r.store.strobe = 1'b0;
    nxt_r.keys_prev    = r_ff.keys;

    // Slave answers one cycle into the access phase
    nxt_r.apb.pready  = acc & ~r_ff.apb.pready;
    nxt_r.apb.pslverr = `SAP_APB_ERR_NONE;
    if (acc && !r_ff.apb.pready) begin
      nxt_r.apb.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `SAP_OFF_SELECTOR, `SAP_OFF_OTHER_CV: nxt_r.apb.prdata = 32'h0000_0000;
        `SAP_OFF_KEYS: nxt_r.apb.prdata = {12'h000, r_ff.keys};
        `SAP_OFF_DRIVE: nxt_r.apb.prdata = {23'h000000, r_ff.dir, r_ff.speed};
        `SAP_OFF_BLOWOFF: nxt_r.apb.prdata = {24'h000000, r_ff.blow_map};
        `SAP_OFF_STATUS: begin
          nxt_r.apb.prdata = {r_ff.sample, r_ff.group, r_ff.target,
                              5'h00, r_ff.kind, r_ff.st == SAP_ACTIVE};
        end
        default: nxt_r.apb.pslverr = 1'b1;
      endcase
    end

    // Procedure keys; one press acted on per cycle, F3 and F8 first
    if (r_ff.st == SAP_ACTIVE) begin
      if (press[`SAP_KEY_CLEAR]) begin
        nxt_r.st           = SAP_IDLE;
        nxt_r.store.strobe = 1'b1;
        nxt_r.store.clear  = 1'b1;
        nxt_r.confirm      = 1'b1;
      end else if (press[`SAP_KEY_STORE]) begin
        nxt_r.st             = SAP_IDLE;
        nxt_r.store.strobe   = 1'b1;
        nxt_r.store.clear    = 1'b0;
        nxt_r.confirm        = 1'b1;
        nxt_r.store.group    = r_ff.group;
        nxt_r.store.sample   = r_ff.sample;
        nxt_r.store.volume   = r_ff.speed;
        // Loop wins when both F6 and F7 are on
        nxt_r.store.rep_loop = r_ff.keys[`SAP_KEY_LOOP];
        nxt_r.store.shorten  = r_ff.keys[`SAP_KEY_SHORT]
                               & ~r_ff.keys[`SAP_KEY_LOOP];
        nxt_r.store.moving   = (r_ff.kind == SAP_RANDOM)
                               & r_ff.keys[`SAP_KEY_SHORT]
                               & ~r_ff.keys[`SAP_KEY_LOOP];
        if (r_ff.kind == SAP_BACKGND && r_ff.target == `SAP_SEL_BLOWOFF) begin
          nxt_r.blow_group  = r_ff.group;
          nxt_r.blow_sample = r_ff.sample;
        end
      end else if (press[`SAP_KEY_PLAY]) begin
        if (lib_group_size == 8'h00) begin
          nxt_r.warn = 1'b1;
        end else begin
          nxt_r.play.strobe = 1'b1;
        end
      end else if (press[`SAP_KEY_PREV]) begin
        if (r_ff.sample == 8'h00) begin
          nxt_r.warn = 1'b1;
        end else begin
          nxt_r.sample      = r_ff.sample - 8'h01;
          nxt_r.play.strobe = 1'b1;
        end
      end else if (press[`SAP_KEY_NEXT]) begin
        if (r_ff.sample + 8'h01 >= lib_group_size) begin
          nxt_r.warn = 1'b1;
        end else begin
          nxt_r.sample      = r_ff.sample + 8'h01;
          nxt_r.play.strobe = 1'b1;
        end
      end else if (press[`SAP_KEY_GPREV] || press[`SAP_KEY_GNEXT]) begin
        // Background selection stays inside its own group
        if (r_ff.kind == SAP_BACKGND) begin
          nxt_r.warn = 1'b1;
        end else if (press[`SAP_KEY_GPREV]) begin
          if (r_ff.group == 8'h00) begin
            nxt_r.warn = 1'b1;
          end else begin
            nxt_r.group       = r_ff.group - 8'h01;
            nxt_r.sample      = 8'h00;
            nxt_r.play.strobe = 1'b1;
          end
        end else if (r_ff.group == LAST_GROUP) begin
          nxt_r.warn = 1'b1;
        end else begin
          nxt_r.group       = r_ff.group + 8'h01;
          nxt_r.sample      = 8'h00;
          nxt_r.play.strobe = 1'b1;
        end
      end else if (press[`SAP_NUM_KEYS-1:`SAP_KEY_STORE+1] != '0) begin
        nxt_r.warn = 1'b1;
      end
    end

    // Register writes take effect on the completing edge
    if (commit) begin
      case (apb_req.paddr)
        `SAP_OFF_SELECTOR: begin
          // Any selector write ends a running procedure unstored
          nxt_r.st     = SAP_IDLE;
          nxt_r.group  = 8'h00;
          nxt_r.sample = 8'h00;
          if (!apb_req.pwdata[`SAP_SEL_SVC_BIT]) begin
            nxt_r.st = SAP_ACTIVE;
            if (sel_val >= `SAP_SEL_FUNC_LO && sel_val <= `SAP_SEL_FUNC_HI) begin
              nxt_r.kind   = SAP_FUNC;
              nxt_r.target = sel_val;
            end else if (sel_val == `SAP_SEL_FUNC_F0) begin
              nxt_r.kind   = SAP_FUNC;
              nxt_r.target = 8'h00;
            end else if (sel_val >= `SAP_SEL_RAND_LO
                         && sel_val <= `SAP_SEL_RAND_HI) begin
              nxt_r.kind   = SAP_RANDOM;
              nxt_r.target = sel_val - `SAP_SEL_RAND_LO;
            end else if (sel_val >= `SAP_SEL_SW_LO
                         && sel_val <= `SAP_SEL_SW_HI) begin
              nxt_r.kind   = SAP_SWITCH;
              nxt_r.target = sel_val - `SAP_SEL_SW_LO;
            end else if ((sel_val >= `SAP_SEL_BG_LO && sel_val <= `SAP_SEL_BG_HI)
                         || sel_val == `SAP_SEL_TURBO
                         || sel_val == `SAP_SEL_DYNBRAKE) begin
              nxt_r.kind   = SAP_BACKGND;
              nxt_r.target = sel_val;
              nxt_r.group  = sel_val - `SAP_SEL_BG_LO;
            end else begin
              nxt_r.st = SAP_IDLE;
            end
          end
        end
        `SAP_OFF_KEYS: nxt_r.keys = apb_req.pwdata[`SAP_NUM_KEYS-1:0];
        `SAP_OFF_DRIVE: begin
          nxt_r.speed = apb_req.pwdata[7:0];
          nxt_r.dir   = apb_req.pwdata[`SAP_DRIVE_DIR_BIT];
        end
        `SAP_OFF_BLOWOFF: begin
          nxt_r.blow_map = apb_req.pwdata[7:0];
          nxt_r.st       = SAP_IDLE;
        end
        `SAP_OFF_OTHER_CV: nxt_r.st = SAP_IDLE;
        default: ;
      endcase
    end

    // Playback request follows the browse position
    nxt_r.play.group   = nxt_r.group;
    nxt_r.play.sample  = nxt_r.sample;
    nxt_r.play.volume  = r_ff.speed;
    nxt_r.store.kind   = r_ff.kind;
    nxt_r.store.target = r_ff.target;

    // Keys drive outputs and sounds only outside a procedure
    nxt_r.drv_speed = r_ff.speed;
    nxt_r.drv_dir   = r_ff.dir;
    if (r_ff.st == SAP_ACTIVE) begin
      nxt_r.func_out  = '0;
      nxt_r.key_sound = '0;
      nxt_r.blow_play = 1'b0;
    end else begin
      nxt_r.func_out  = r_ff.keys;
      nxt_r.key_sound = r_ff.keys;
      nxt_r.blow_play = (r_ff.blow_map != 8'h00)
                        && (r_ff.blow_map < 8'(`SAP_NUM_KEYS))
                        && r_ff.keys[r_ff.blow_map[4:0]];
    end
  end

  // State register; reset doubles as power loss, leaving no procedure
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_ff          <= '0;
      r_ff.st       <= SAP_IDLE;
      r_ff.blow_map <= `SAP_BLOWOFF_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp        = r_ff.apb;
  assign play           = r_ff.play;
  assign warn_jingle    = r_ff.warn;
  assign confirm_jingle = r_ff.confirm;
  assign store          = r_ff.store;
  assign func_out       = r_ff.func_out;
  assign key_sound      = r_ff.key_sound;
  assign blowoff_play   = r_ff.blow_play;
  assign blowoff_group  = r_ff.blow_group;
  assign blowoff_sample = r_ff.blow_sample;
  assign drive_speed    = r_ff.drv_speed;
  assign drive_dir      = r_ff.drv_dir;
  assign proc_active    = r_ff.st == SAP_ACTIVE;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Checks on the engine
  play_volume_a: assert property (
    play.strobe |-> play.volume == $past(r_ff.speed))
    else $error("play volume not taken from regulator");
  fout_mask_a: assert property (
    r_ff.st == SAP_ACTIVE |=> func_out == '0)
    else $error("function outputs moved during procedure");
  confirm_end_a: assert property (
    $rose(r_ff.confirm) |-> $past(r_ff.st) == SAP_ACTIVE
      && $past(press[`SAP_KEY_CLEAR] | press[`SAP_KEY_STORE]))
    else $error("confirmation without F3 or F8");
  clear_end_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_CLEAR] && !commit
      |=> store.strobe && store.clear && r_ff.st == SAP_IDLE)
    else $error("F3 did not clear and end");
  abort_keep_a: assert property (
    commit && apb_req.paddr == `SAP_OFF_OTHER_CV
      |=> r_ff.st == SAP_IDLE ##1 !store.strobe)
    else $error("abort did not end without store");
  loop_mode_a: assert property (
    store.strobe && !store.clear |-> store.rep_loop
      == $past(r_ff.keys[`SAP_KEY_LOOP]))
    else $error("loop flag not F6 at exit");
  full_len_a: assert property (
    store.strobe && !store.clear && !$past(r_ff.keys[`SAP_KEY_LOOP])
      && !$past(r_ff.keys[`SAP_KEY_SHORT])
      |-> !store.rep_loop && !store.shorten && !store.moving)
    else $error("full length not kept");
  start_f0_a: assert property (
    commit && apb_req.paddr == `SAP_OFF_SELECTOR
      && apb_req.pwdata[8:0] == 9'h014
      |=> r_ff.st == SAP_ACTIVE && r_ff.target == 8'h00
      && r_ff.kind == SAP_FUNC)
    else $error("value 20 did not start F0 allocation");
  bg_group_a: assert property (
    r_ff.st == SAP_ACTIVE && r_ff.kind == SAP_BACKGND && !commit
      && press[`SAP_KEY_GNEXT] && press[3:0] == 4'h0 && !press[8]
      |=> warn_jingle && $stable(r_ff.group))
    else $error("background group switched");

  // Checks on browse, store, start and abort commands and on key sound masking
  shorten_mode_a: assert property (
    store.strobe && !store.clear |-> store.shorten
      == ($past(r_ff.keys[`SAP_KEY_SHORT])
          && !$past(r_ff.keys[`SAP_KEY_LOOP])))
    else $error("shorten flag not F7 alone at exit");
  moving_mode_a: assert property (
    store.strobe && !store.clear |-> store.moving
      == (store.kind == SAP_RANDOM && $past(r_ff.keys[`SAP_KEY_SHORT])
          && !$past(r_ff.keys[`SAP_KEY_LOOP])))
    else $error("moving flag not F7 alone on random");
  store_last_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_STORE]
      && !press[`SAP_KEY_CLEAR] && !commit
      |=> store.strobe && !store.clear && r_ff.st == SAP_IDLE
      && store.group == $past(r_ff.group)
      && store.sample == $past(r_ff.sample))
    else $error("F8 did not store the last sample");
  play_eval_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_PLAY] && !commit
      && !press[`SAP_KEY_CLEAR] && !press[`SAP_KEY_STORE]
      && lib_group_size != 8'h00
      |=> play.strobe && play.sample == $past(r_ff.sample))
    else $error("F0 did not play the current sample");
  empty_warn_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_PLAY]
      && !press[`SAP_KEY_CLEAR] && !press[`SAP_KEY_STORE]
      && lib_group_size == 8'h00
      |=> warn_jingle && !play.strobe)
    else $error("empty playback gave no warning");
  prev_step_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_PREV] && !commit
      && !press[`SAP_KEY_PLAY] && !press[`SAP_KEY_CLEAR]
      && !press[`SAP_KEY_STORE] && r_ff.sample != 8'h00
      |=> play.strobe && r_ff.sample == $past(r_ff.sample) - 8'h01)
    else $error("F1 did not step back and play");
  next_step_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_NEXT] && !commit
      && press[`SAP_KEY_PREV:`SAP_KEY_PLAY] == 2'b00
      && !press[`SAP_KEY_CLEAR] && !press[`SAP_KEY_STORE]
      && r_ff.sample + 8'h01 < lib_group_size
      |=> play.strobe && r_ff.sample == $past(r_ff.sample) + 8'h01)
    else $error("F2 did not step on and play");
  group_next_a: assert property (
    r_ff.st == SAP_ACTIVE && r_ff.kind != SAP_BACKGND && !commit
      && press[`SAP_KEY_GNEXT] && press[`SAP_KEY_GPREV:0] == 5'h00
      && !press[`SAP_KEY_STORE] && r_ff.group != LAST_GROUP
      |=> play.strobe && play.sample == 8'h00
      && play.group == $past(r_ff.group) + 8'h01)
    else $error("F5 did not open the next group");
  bad_key_a: assert property (
    r_ff.st == SAP_ACTIVE && press[`SAP_KEY_STORE:0] == 9'h000
      && press[`SAP_NUM_KEYS-1:`SAP_KEY_STORE+1] != '0
      |=> warn_jingle)
    else $error("invalid key gave no warning");
  ksound_mask_a: assert property (
    r_ff.st == SAP_ACTIVE |=> key_sound == '0 && !blowoff_play)
    else $error("key sounds moved during procedure");
  blow_select_a: assert property (
    r_ff.st == SAP_ACTIVE && r_ff.kind == SAP_BACKGND
      && r_ff.target == `SAP_SEL_BLOWOFF && press[`SAP_KEY_STORE]
      && !press[`SAP_KEY_CLEAR]
      |=> blowoff_group == $past(r_ff.group)
      && blowoff_sample == $past(r_ff.sample))
    else $error("blow-off key sample not the selected one");
  abort_sel_a: assert property (
    commit && apb_req.paddr == `SAP_OFF_SELECTOR
      && apb_req.pwdata[7:0] == 8'h00
      |=> r_ff.st == SAP_IDLE ##1 !store.strobe && !confirm_jingle)
    else $error("selector 0 did not abort unstored");
  start_bg_a: assert property (
    commit && apb_req.paddr == `SAP_OFF_SELECTOR
      && !apb_req.pwdata[`SAP_SEL_SVC_BIT]
      && (apb_req.pwdata[7:0] inside {[`SAP_SEL_BG_LO:`SAP_SEL_BG_HI],
          `SAP_SEL_TURBO, `SAP_SEL_DYNBRAKE})
      |=> r_ff.st == SAP_ACTIVE && r_ff.kind == SAP_BACKGND
      && r_ff.target == $past(apb_req.pwdata[7:0]))
    else $error("background value did not start selection");
  start_rand_a: assert property (
    commit && apb_req.paddr == `SAP_OFF_SELECTOR
      && !apb_req.pwdata[`SAP_SEL_SVC_BIT]
      && apb_req.pwdata[7:0] inside {[`SAP_SEL_RAND_LO:`SAP_SEL_RAND_HI]}
      |=> r_ff.st == SAP_ACTIVE && r_ff.kind == SAP_RANDOM
      && r_ff.target == $past(apb_req.pwdata[7:0]) - `SAP_SEL_RAND_LO)
    else $error("random value did not start allocation");
endmodule

/* sap_defs.svh */
// Constants of the sound assignment procedure block: offsets, fields,
// reset values and selector codes. Included by the package and the core.
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

// Register byte offsets on the APB slave
`define SAP_OFF_SELECTOR 12'h000
`define SAP_OFF_KEYS     12'h004
`define SAP_OFF_DRIVE    12'h008
`define SAP_OFF_BLOWOFF  12'h00C
`define SAP_OFF_STATUS   12'h010
`define SAP_OFF_OTHER_CV 12'h014

// Field positions
`define SAP_SEL_SVC_BIT   8
`define SAP_DRIVE_DIR_BIT 8
`define SAP_ST_ACTIVE_BIT 0

// Reset values
`define SAP_BLOWOFF_RST 8'h04
`define SAP_APB_ERR_NONE 1'b0

// Selector codes
`define SAP_SEL_FUNC_LO  8'h01
`define SAP_SEL_FUNC_HI  8'h13
`define SAP_SEL_FUNC_F0  8'h14
`define SAP_SEL_RAND_LO  8'h65
`define SAP_SEL_RAND_HI  8'h6C
`define SAP_SEL_SW_LO    8'h6F
`define SAP_SEL_SW_HI    8'h71
`define SAP_SEL_BG_LO    8'h80
`define SAP_SEL_BG_HI    8'h89
`define SAP_SEL_TURBO    8'h8D
`define SAP_SEL_DYNBRAKE 8'h8E
`define SAP_SEL_BLOWOFF  8'h85

// Function key numbers with a role during a procedure
`define SAP_KEY_PLAY  0
`define SAP_KEY_PREV  1
`define SAP_KEY_NEXT  2
`define SAP_KEY_CLEAR 3
`define SAP_KEY_GPREV 4
`define SAP_KEY_GNEXT 5
`define SAP_KEY_LOOP  6
`define SAP_KEY_SHORT 7
`define SAP_KEY_STORE 8
`define SAP_NUM_KEYS  20

`endif

/* sap_lib_model.sv */
// Sound library stand-in: reports the sample count of the addressed group.
// Assumes the group index comes from the block's playback request.
module sap_lib_model (
  input  sap_pkg::sap_play_t play,
  output logic [7:0]         lib_group_size
);
  timeunit 1ns;
  timeprecision 1ps;
  import sap_pkg::*;

  // Sizes chosen so both list ends and an empty group are reached quickly
  always_comb begin
    case (play.group)
      8'h00:   lib_group_size = 8'h03;
      8'h01:   lib_group_size = 8'h02;
      8'h02:   lib_group_size = 8'h00;
      8'h03:   lib_group_size = 8'h02;
      8'h05:   lib_group_size = 8'h02;
      default: lib_group_size = 8'h01;
    endcase
  end
endmodule

/* sap_pkg.sv */
// Types of the sound assignment procedure block.
// Assumes sap_defs.svh is on the include path.
`include "sap_defs.svh"
package sap_pkg;
  typedef enum logic {SAP_IDLE, SAP_ACTIVE} sap_state_t;
  typedef enum logic [1:0] {SAP_FUNC, SAP_BACKGND, SAP_RANDOM, SAP_SWITCH} sap_kind_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } sap_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sap_apb_rsp_t;

  typedef struct packed {
    logic       strobe;
    logic [7:0] group;
    logic [7:0] sample;
    logic [7:0] volume;
  } sap_play_t;

  typedef struct packed {
    logic       strobe;
    logic       clear;
    sap_kind_t  kind;
    logic [7:0] target;
    logic [7:0] group;
    logic [7:0] sample;
    logic [7:0] volume;
    logic       rep_loop;
    logic       shorten;
    logic       moving;
  } sap_store_t;

  typedef struct packed {
    sap_state_t                st;
    sap_kind_t                 kind;
    logic [7:0]                target;
    logic [7:0]                group;
    logic [7:0]                sample;
    logic [`SAP_NUM_KEYS-1:0]  keys;
    logic [`SAP_NUM_KEYS-1:0]  keys_prev;
    logic [7:0]                speed;
    logic                      dir;
    logic [7:0]                blow_map;
    logic [7:0]                blow_group;
    logic [7:0]                blow_sample;
    sap_apb_rsp_t              apb;
    sap_play_t                 play;
    logic                      warn;
    logic                      confirm;
    sap_store_t                store;
    logic [`SAP_NUM_KEYS-1:0]  func_out;
    logic [`SAP_NUM_KEYS-1:0]  key_sound;
    logic                      blow_play;
    logic [7:0]                drv_speed;
    logic                      drv_dir;
  } sap_regs_t;
endpackage

/* tb_top.sv */
// Self-checking bench of the sound assignment procedure engine.
// Assumes sap_pkg, sap_defs.svh and sap_core are compiled first.
`include "sap_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sap_pkg::*;
  logic                     ref_clk = 1'b0;
  logic                     rst;
  sap_apb_req_t             req;
  sap_apb_rsp_t             rsp;
  logic [7:0]               gsize;
  sap_play_t                play;
  logic                     warn;
  logic                     conf;
  sap_store_t               store;
  logic [`SAP_NUM_KEYS-1:0] func_out;
  logic [`SAP_NUM_KEYS-1:0] key_sound;
  logic                     bp;
  logic [7:0]               bg;
  logic [7:0]               bs;
  logic [7:0]               dspd;
  logic                     ddir;
  logic                     act;
  logic [31:0]              rd;
  logic                     er;
  sap_play_t                lp = '0;
  sap_store_t               ls = '0;
  int                       n_play = 0;
  int                       n_warn = 0;
  int                       n_conf = 0;
  int                       n_store = 0;
  int                       errors = 0;
  int                       check_count = 0;

  sap_core #(.NUM_GROUPS(4)) u_sap_core (
    .ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .lib_group_size(gsize), .play(play), .warn_jingle(warn),
    .confirm_jingle(conf), .store(store), .func_out(func_out),
    .key_sound(key_sound), .blowoff_play(bp), .blowoff_group(bg),
    .blowoff_sample(bs), .drive_speed(dspd), .drive_dir(ddir),
    .proc_active(act)
  );
  sap_lib_model u_sap_lib_model (.play(play), .lib_group_size(gsize));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Capture the one-cycle pulses so scenarios can judge them later
  always @(posedge ref_clk) begin
    if (play.strobe === 1'b1) begin
      n_play <= n_play + 1;
      lp <= play;
    end
    if (warn === 1'b1) n_warn <= n_warn + 1;
    if (conf === 1'b1) n_conf <= n_conf + 1;
    if (store.strobe === 1'b1) begin
      n_store <= n_store + 1;
      ls <= store;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask

  // Write, then let the pulses that follow it land
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic press(input int k, input logic [19:0] base);
    wr(`SAP_OFF_KEYS, {12'h0, base | (20'h1 << k)});
    wr(`SAP_OFF_KEYS, {12'h0, base});
  endtask

  task automatic t_reset;
    chk(act, 0);
    chk(func_out, 0);
    apb(`SAP_OFF_BLOWOFF, 1'b0, 0);
    chk(rd, 32'h4);
    apb(12'h018, 1'b0, 0);
    chk(er, 1);
  endtask

  task automatic t_func;
    int w;
    wr(`SAP_OFF_DRIVE, 32'h140);
    chk({ddir, dspd}, 9'h140);
    wr(`SAP_OFF_SELECTOR, 3);
    chk(act, 1);
    apb(`SAP_OFF_STATUS, 1'b0, 0);
    chk(rd, 32'h301);
    w = n_play;
    press(2, 0);
    chk(n_play - w, 1);
    chk({lp.group, lp.sample, lp.volume}, 24'h000140);
    press(2, 0);
    w = n_warn;
    press(2, 0);
    chk(n_warn - w, 1);
    press(1, 0);
    press(0, 0);
    chk(lp.sample, 1);
    chk(func_out, 0);
    w = n_conf;
    press(8, 20'h40);
    chk(n_conf - w, 1);
    chk({ls.clear, ls.kind, ls.target, ls.group, ls.sample}, 27'h0030001);
    chk({ls.volume, ls.rep_loop, ls.shorten}, 10'h102);
    chk(act, 0);
    wr(`SAP_OFF_KEYS, 32'h8);
    chk({key_sound[3], func_out[3]}, 2'b11);
    wr(`SAP_OFF_KEYS, 0);
  endtask

  task automatic t_groups;
    int w;
    wr(`SAP_OFF_SELECTOR, 20);
    press(5, 0);
    chk({lp.group, lp.sample}, 16'h0100);
    press(4, 0);
    chk(lp.group, 0);
    w = n_warn;
    press(4, 0);
    press(9, 0);
    chk(n_warn - w, 2);
    press(5, 0);
    press(5, 0);
    w = n_warn;
    press(0, 0);
    chk(n_warn - w, 1);
    press(5, 0);
    w = n_warn;
    press(5, 0);
    chk(n_warn - w, 1);
    press(8, 20'h80);
    chk({ls.target, ls.group, ls.rep_loop, ls.shorten}, 18'h0000D);
    wr(`SAP_OFF_KEYS, 0);
  endtask

  task automatic t_bg;
    logic [7:0] codes [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                               8'h86, 8'h87, 8'h88, 8'h89, 8'h8D, 8'h8E};
    int w;
    for (int i = 0; i < 12; i++) begin
      wr(`SAP_OFF_SELECTOR, codes[i]);
      w = n_warn;
      press(5, 0);
      chk(n_warn - w, 1);
      if (codes[i] == 8'h85) press(2, 0);
      press(8, 0);
      chk({ls.kind, ls.target, ls.volume}, {SAP_BACKGND, codes[i], 8'h40});
    end
    chk({bg, bs}, 16'h0501);
    wr(`SAP_OFF_KEYS, 32'h10);
    chk(bp, 1);
    wr(`SAP_OFF_KEYS, 0);
    wr(`SAP_OFF_BLOWOFF, 0);
    wr(`SAP_OFF_KEYS, 32'h10);
    chk(bp, 0);
    wr(`SAP_OFF_KEYS, 0);
  endtask

  task automatic t_rand_switch;
    for (int i = 0; i < 8; i++) begin
      wr(`SAP_OFF_SELECTOR, 101 + i);
      apb(`SAP_OFF_STATUS, 1'b0, 0);
      chk(rd[15:0], {i[7:0], 8'h05});
      press(8, (i == 7) ? 20'h80 : 20'h40);
      chk({ls.target, ls.moving}, {i[7:0], i == 7});
      wr(`SAP_OFF_KEYS, 0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`SAP_OFF_SELECTOR, 111 + i);
      press(8, 0);
      chk({ls.kind, ls.target, ls.rep_loop, ls.shorten}, {SAP_SWITCH, i[7:0], 2'b00});
    end
  endtask

  task automatic t_abort;
    int s;
    int c;
    wr(`SAP_OFF_SELECTOR, 5);
    press(3, 0);
    chk({ls.clear, ls.target}, 9'h105);
    s = n_store;
    c = n_conf;
    wr(`SAP_OFF_SELECTOR, 6);
    press(2, 0);
    wr(`SAP_OFF_OTHER_CV, 1);
    chk(act, 0);
    wr(`SAP_OFF_SELECTOR, 7);
    wr(`SAP_OFF_SELECTOR, 0);
    chk(act, 0);
    wr(`SAP_OFF_SELECTOR, 7);
    wr(`SAP_OFF_SELECTOR, 32'h107);
    chk(act, 0);
    apb(`SAP_OFF_SELECTOR, 1'b0, 0);
    chk(rd, 0);
    wr(`SAP_OFF_SELECTOR, 9);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(act, 0);
    chk(n_store - s, 0);
    chk(n_conf - c, 0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    req = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_func;
    t_groups;
    t_bg;
    t_rand_switch;
    t_abort;
    report_and_stop;
  end
endmodule
